/* File: rtl/dtc_timer_top.sv */
// two counter/timers with shared control register and external interrupt flags
module dtc_timer_top (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata_ff,
  input  wire logic       timer0_count_pin,
  input  wire logic       timer1_count_pin,
  input  wire logic       ext_irq0_input,
  input  wire logic       ext_irq1_input,
  input  wire logic       ext_irq0_polarity,
  input  wire logic       ext_irq1_polarity,
  input  wire logic       timer0_clock_select,
  input  wire logic       timer1_clock_select,
  input  wire logic       timer0_vector_ack,
  input  wire logic       timer1_vector_ack,
  input  wire logic       ext_irq0_vector_ack,
  input  wire logic       ext_irq1_vector_ack,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  output logic            ext_irq0_flag,
  output logic            ext_irq1_flag
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dtc_pkg::dtc_ctrl_t ctrl_ff;      // run, type and overflow bits
  dtc_pkg::dtc_ctrl_t nxt_ctrl;
  dtc_pkg::dtc_mode_t mode_ff;      // gate, source and mode fields
  dtc_pkg::dtc_mode_t nxt_mode;
  logic [7:0]         tl0_ff;       // timer 0 low byte
  logic [7:0]         th0_ff;       // timer 0 high byte
  logic [7:0]         tl1_ff;       // timer 1 low byte
  logic [7:0]         th1_ff;       // timer 1 high byte
  logic [7:0]         nxt_tl0;
  logic [7:0]         nxt_th0;
  logic [7:0]         nxt_tl1;
  logic [7:0]         nxt_th1;
  logic [1:0]         pin_prev_ff;  // count pins one cycle ago
  logic [7:0]         nxt_rdata;

  // ----------------------------------------------------------------------
  // derived strobes
  // ----------------------------------------------------------------------
  logic               pre_tick;     // slow tick from the prescaler
  logic [1:0]         ext_active;   // external inputs at active level
  logic [1:0]         ext_flag;     // sticky external flags
  logic [1:0]         ext_in;
  logic [1:0]         ext_pol;
  logic [1:0]         ext_type;
  logic [1:0]         ext_wval;
  logic [1:0]         ext_ack;
  logic               wr_ctrl;
  logic               tick0;
  logic               tick1;
  logic               fall0;
  logic               fall1;
  logic               inc0;         // timer 0 low part advances
  logic               inc0_hi;      // split mode high byte advances
  logic               inc1;         // timer 1 advances
  dtc_pkg::dtc_count_t step0;
  dtc_pkg::dtc_count_t step0_hi;
  dtc_pkg::dtc_count_t step1;
  logic               set_tf0;
  logic               set_tf1;

  // ----------------------------------------------------------------------
  // counter step for one timer in the given mode
  // ----------------------------------------------------------------------
  function automatic dtc_pkg::dtc_count_t dtc_step(
    input logic [1:0] mode,
    input logic [7:0] tl,
    input logic [7:0] th
  );
    logic [12:0] c13;
    logic [15:0] c16;
    dtc_step = '{ovf: 1'b0, th: th, tl: tl};
    c13      = {th, tl[dtc_pkg::MODE0_LOW_BITS-1:0]} + 13'h0001;
    c16      = {th, tl} + 16'h0001;
    case (mode)
      dtc_pkg::MODE_13BIT: begin
        // upper low-byte bits are left as they are
        dtc_step.ovf = &{th, tl[dtc_pkg::MODE0_LOW_BITS-1:0]};
        dtc_step.th  = c13[12:dtc_pkg::MODE0_LOW_BITS];
        dtc_step.tl  = {tl[7:dtc_pkg::MODE0_LOW_BITS], c13[dtc_pkg::MODE0_LOW_BITS-1:0]};
      end
      dtc_pkg::MODE_16BIT: begin
        dtc_step.ovf = &{th, tl};
        dtc_step.th  = c16[15:8];
        dtc_step.tl  = c16[7:0];
      end
      dtc_pkg::MODE_RELOAD: begin
        // high byte is the reload value and never counts
        dtc_step.ovf = &tl;
        dtc_step.tl  = (&tl) ? th : tl + 8'h01;
      end
      default: begin
        // plain 8-bit wrap, used by split mode
        dtc_step.ovf = &tl;
        dtc_step.tl  = tl + 8'h01;
      end
    endcase
  endfunction : dtc_step

  // ----------------------------------------------------------------------
  // slow tick and external interrupt inputs
  // ----------------------------------------------------------------------
  dtc_prescaler u_prescaler (
    .clk     (clk),
    .srst    (srst),
    .tick_ff (pre_tick)
  );

  assign wr_ctrl  = sfr_wr && (sfr_addr == dtc_pkg::ADDR_CTRL);
  assign ext_in   = {ext_irq1_input, ext_irq0_input};
  assign ext_pol  = {ext_irq1_polarity, ext_irq0_polarity};
  assign ext_type = {ctrl_ff.xtyp1, ctrl_ff.xtyp0};
  assign ext_wval = {sfr_wdata[3], sfr_wdata[1]};
  assign ext_ack  = {ext_irq1_vector_ack, ext_irq0_vector_ack};

  // one detector per external input
  for (genvar i = 0; i < 2; i++) begin : g_ext
    dtc_ext_irq u_ext (
      .clk        (clk),
      .srst       (srst),
      .irq_input  (ext_in[i]),
      .polarity   (ext_pol[i]),
      .edge_mode  (ext_type[i]),
      .sw_write   (wr_ctrl),
      .sw_value   (ext_wval[i]),
      .vector_ack (ext_ack[i]),
      .active     (ext_active[i]),
      .flag_ff    (ext_flag[i])
    );
  end

  // ----------------------------------------------------------------------
  // count enables: run, gate, and source select
  // ----------------------------------------------------------------------
  always_comb begin
    tick0   = timer0_clock_select | pre_tick;
    tick1   = timer1_clock_select | pre_tick;
    fall0   = pin_prev_ff[0] & ~timer0_count_pin;
    fall1   = pin_prev_ff[1] & ~timer1_count_pin;
    inc0    = ctrl_ff.run0 && (!mode_ff.gate_en0 || ext_active[0])
              && (mode_ff.src0 ? fall0 : tick0);
    // split mode: high byte of timer 0 borrows timer 1's run bit
    inc0_hi = (mode_ff.mode0 == dtc_pkg::MODE_SPLIT) && ctrl_ff.run1 && tick0;
    inc1    = ctrl_ff.run1 && (!mode_ff.gate_en1 || ext_active[1])
              && (mode_ff.src1 ? fall1 : tick1)
              && (mode_ff.mode1 != dtc_pkg::MODE_SPLIT);
  end

  // ----------------------------------------------------------------------
  // counter next values: software writes win over counting
  // ----------------------------------------------------------------------
  always_comb begin
    step0    = dtc_step(mode_ff.mode0, tl0_ff, th0_ff);
    step0_hi = dtc_step(dtc_pkg::MODE_SPLIT, th0_ff, th0_ff);
    step1    = dtc_step(mode_ff.mode1, tl1_ff, th1_ff);
    nxt_tl0  = inc0 ? step0.tl : tl0_ff;
    nxt_th0  = (mode_ff.mode0 == dtc_pkg::MODE_SPLIT) ? (inc0_hi ? step0_hi.tl : th0_ff)
                                                      : (inc0 ? step0.th : th0_ff);
    nxt_tl1  = inc1 ? step1.tl : tl1_ff;
    nxt_th1  = inc1 ? step1.th : th1_ff;
    if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_TL0)) nxt_tl0 = sfr_wdata;
    if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_TH0)) nxt_th0 = sfr_wdata;
    if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_TL1)) nxt_tl1 = sfr_wdata;
    if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_TH1)) nxt_th1 = sfr_wdata;
  end

  // ----------------------------------------------------------------------
  // control, mode and read data next values
  // ----------------------------------------------------------------------
  always_comb begin
    set_tf0  = inc0 && step0.ovf;
    // in split mode timer 1 keeps running but its flag belongs to timer 0's high byte
    set_tf1  = (mode_ff.mode0 == dtc_pkg::MODE_SPLIT) ? (inc0_hi && step0_hi.ovf)
                                                      : (inc1 && step1.ovf);
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    if (wr_ctrl) begin
      nxt_ctrl = dtc_pkg::dtc_ctrl_t'(sfr_wdata);
    end
    if (sfr_wr && (sfr_addr == dtc_pkg::ADDR_MODE)) begin
      nxt_mode = dtc_pkg::dtc_mode_t'(sfr_wdata);
    end
    // vector clear, then hardware set on top so a same-cycle overflow is kept
    if (!wr_ctrl && timer0_vector_ack) nxt_ctrl.ovf0 = 1'b0;
    if (!wr_ctrl && timer1_vector_ack) nxt_ctrl.ovf1 = 1'b0;
    nxt_ctrl.ovf0 = nxt_ctrl.ovf0 | set_tf0;
    nxt_ctrl.ovf1 = nxt_ctrl.ovf1 | set_tf1;
    // external flags live in the detectors
    nxt_ctrl.xflg0 = 1'b0;
    nxt_ctrl.xflg1 = 1'b0;
    nxt_rdata    = sfr_rdata_ff;
    if (sfr_rd) begin
      case (sfr_addr)
        dtc_pkg::ADDR_CTRL: nxt_rdata = {ctrl_ff.ovf1, ctrl_ff.run1, ctrl_ff.ovf0, ctrl_ff.run0,
                                         ext_flag[1], ctrl_ff.xtyp1, ext_flag[0], ctrl_ff.xtyp0};
        dtc_pkg::ADDR_MODE: nxt_rdata = mode_ff;
        dtc_pkg::ADDR_TL0:  nxt_rdata = tl0_ff;
        dtc_pkg::ADDR_TH0:  nxt_rdata = th0_ff;
        dtc_pkg::ADDR_TL1:  nxt_rdata = tl1_ff;
        dtc_pkg::ADDR_TH1:  nxt_rdata = th1_ff;
        default:            nxt_rdata = dtc_pkg::RDATA_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers only
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff      <= dtc_pkg::dtc_ctrl_t'(dtc_pkg::CTRL_RESET);
      mode_ff      <= dtc_pkg::dtc_mode_t'(dtc_pkg::MODE_RESET);
      tl0_ff       <= dtc_pkg::COUNT_RESET;
      th0_ff       <= dtc_pkg::COUNT_RESET;
      tl1_ff       <= dtc_pkg::COUNT_RESET;
      th1_ff       <= dtc_pkg::COUNT_RESET;
      pin_prev_ff  <= '0;
      sfr_rdata_ff <= dtc_pkg::RDATA_IDLE;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      mode_ff      <= nxt_mode;
      tl0_ff       <= nxt_tl0;
      th0_ff       <= nxt_th0;
      tl1_ff       <= nxt_tl1;
      th1_ff       <= nxt_th1;
      pin_prev_ff  <= {timer1_count_pin, timer0_count_pin};
      sfr_rdata_ff <= nxt_rdata;
    end
  end

  // flags straight from flip-flops
  assign timer0_overflow_flag = ctrl_ff.ovf0;
  assign timer1_overflow_flag = ctrl_ff.ovf1;
  assign ext_irq0_flag        = ext_flag[0];
  assign ext_irq1_flag        = ext_flag[1];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic wr_tl0;
  logic wr_tl1;
  assign wr_tl0 = sfr_wr && (sfr_addr == dtc_pkg::ADDR_TL0);
  assign wr_tl1 = sfr_wr && (sfr_addr == dtc_pkg::ADDR_TL1);

  property p_tf0_set;
    @(posedge clk) disable iff (srst) (inc0 && step0.ovf) |=> ctrl_ff.ovf0;
  endproperty
  a_tf0_set: assert property (p_tf0_set)
    else $error("timer 0 overflow lost");

  property p_tf1_set;
    @(posedge clk) disable iff (srst)
      (mode_ff.mode0 != dtc_pkg::MODE_SPLIT && inc1 && step1.ovf) |=> ctrl_ff.ovf1;
  endproperty
  a_tf1_set: assert property (p_tf1_set)
    else $error("timer 1 overflow lost");

  property p_tmr0_stopped;
    @(posedge clk) disable iff (srst)
      (!ctrl_ff.run0 && !wr_tl0) |=> (tl0_ff == $past(tl0_ff));
  endproperty
  a_tmr0_stopped: assert property (p_tmr0_stopped)
    else $error("timer 0 moved while stopped");

  property p_tmr1_stopped;
    @(posedge clk) disable iff (srst)
      (!ctrl_ff.run1 && !wr_tl1) |=> $stable(tl1_ff);
  endproperty
  a_tmr1_stopped: assert property (p_tmr1_stopped)
    else $error("timer 1 moved while stopped");

  property p_tmr0_gated;
    @(posedge clk) disable iff (srst)
      (mode_ff.gate_en0 && !ext_active[0] && !wr_tl0) |=> $stable(tl0_ff);
  endproperty
  a_tmr0_gated: assert property (p_tmr0_gated)
    else $error("timer 0 counted with gate closed");

  property p_tmr0_pin;
    @(posedge clk) disable iff (srst)
      (mode_ff.src0 && !fall0 && !wr_tl0) |=> $stable(tl0_ff);
  endproperty
  a_tmr0_pin: assert property (p_tmr0_pin)
    else $error("timer 0 counted without pin fall");

  property p_tmr1_inactive;
    @(posedge clk) disable iff (srst)
      (mode_ff.mode1 == dtc_pkg::MODE_SPLIT && !wr_tl1) [*2] |-> $stable(tl1_ff);
  endproperty
  a_tmr1_inactive: assert property (p_tmr1_inactive)
    else $error("timer 1 counted while inactive");

  property p_tmr0_reload;
    @(posedge clk) disable iff (srst)
      (mode_ff.mode0 == dtc_pkg::MODE_RELOAD && inc0 && (&tl0_ff) && !wr_tl0)
        |=> (tl0_ff == $past(th0_ff)) && ctrl_ff.ovf0;
  endproperty
  a_tmr0_reload: assert property (p_tmr0_reload)
    else $error("timer 0 reload wrong");

  c_tmr0_ovf:    cover property (@(posedge clk) disable iff (srst) $rose(ctrl_ff.ovf0));
  c_tmr0_split:  cover property (@(posedge clk) disable iff (srst) inc0_hi && step0_hi.ovf);
  c_tmr1_reload: cover property (@(posedge clk) disable iff (srst)
    mode_ff.mode1 == dtc_pkg::MODE_RELOAD && inc1 && step1.ovf);

endmodule : dtc_timer_top

/* File: rtl/dtc_pkg.sv */
// shared constants and types for the dual timer/counter with external interrupt flags
package dtc_pkg;

  // ----------------------------------------------------------------------
  // special function register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h88;  // control and flags
  localparam logic [7:0] ADDR_MODE     = 8'h89;  // gate, source and mode fields
  localparam logic [7:0] ADDR_TL0      = 8'h8A;  // timer 0 low byte
  localparam logic [7:0] ADDR_TL1      = 8'h8B;  // timer 1 low byte
  localparam logic [7:0] ADDR_TH0      = 8'h8C;  // timer 0 high byte
  localparam logic [7:0] ADDR_TH1      = 8'h8D;  // timer 1 high byte

  // ----------------------------------------------------------------------
  // reset values and read answer for unmapped addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] RDATA_IDLE    = 8'h00;

  // ----------------------------------------------------------------------
  // operating modes of the two-bit mode fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT    = 2'h0;   // 13-bit counter
  localparam logic [1:0] MODE_16BIT    = 2'h1;   // 16-bit counter
  localparam logic [1:0] MODE_RELOAD   = 2'h2;   // 8-bit with auto-reload
  localparam logic [1:0] MODE_SPLIT    = 2'h3;   // timer 0: two 8-bit, timer 1: inactive

  // low-byte bits used in 13-bit mode
  localparam int         MODE0_LOW_BITS = 5;

  // ----------------------------------------------------------------------
  // prescaler: system clock divided by this for the slow timer tick
  // ----------------------------------------------------------------------
  localparam int         PRESCALE_DIV  = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

  // control register layout, bit 7 first
  typedef struct packed {
    logic ovf1;  logic run1;  logic ovf0;  logic run0;
    logic xflg1; logic xtyp1; logic xflg0; logic xtyp0;
  } dtc_ctrl_t;

  // mode register layout, bit 7 first
  typedef struct packed {
    logic       gate_en1;
    logic       src1;
    logic [1:0] mode1;
    logic       gate_en0;
    logic       src0;
    logic [1:0] mode0;
  } dtc_mode_t;

  // one counter step result
  typedef struct packed {
    logic       ovf;
    logic [7:0] th;
    logic [7:0] tl;
  } dtc_count_t;

endpackage : dtc_pkg

/* File: rtl/dtc_prescaler.sv */
// divider that makes the slow timer tick as a one-cycle enable
module dtc_prescaler (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick_ff
);

  logic [3:0] cnt_ff;       // cycle counter
  logic [3:0] nxt_cnt;
  logic       nxt_tick;

  // ----------------------------------------------------------------------
  // next state: wrap at the last count and pulse once per period
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_tick = (cnt_ff == dtc_pkg::PRESCALE_LAST);
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + 4'h1;
  end

  // registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

endmodule : dtc_prescaler

/* File: rtl/dtc_ext_irq.sv */
// one external interrupt input: polarity, edge or level detect, sticky flag
module dtc_ext_irq (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic irq_input,    // pin level
  input  wire logic polarity,     // 1: active high, 0: active low
  input  wire logic edge_mode,    // 1: edge, 0: level
  input  wire logic sw_write,     // control register written this cycle
  input  wire logic sw_value,     // value written to the flag
  input  wire logic vector_ack,   // cpu vectors to this routine
  output logic      active,       // input at its active level
  output logic      flag_ff       // sticky request flag
);

  logic prev_active_ff;           // active level one cycle ago
  logic set_evt;
  logic nxt_flag;

  assign active = (irq_input == polarity);

  // ----------------------------------------------------------------------
  // next state: hardware set wins over software write and vector clear
  // ----------------------------------------------------------------------
  always_comb begin
    set_evt  = edge_mode ? (active & ~prev_active_ff) : active;
    nxt_flag = set_evt | (sw_write ? sw_value
                                   : ((vector_ack & edge_mode) ? 1'b0 : flag_ff));
  end

  // registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_active_ff <= 1'b0;
      flag_ff        <= 1'b0;
    end else begin
      prev_active_ff <= active;
      flag_ff        <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_edge_sets;
    @(posedge clk) disable iff (srst)
      (edge_mode && active && !prev_active_ff) |=> flag_ff;
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge detect did not raise flag");

  property p_level_holds;
    @(posedge clk) disable iff (srst)
      (!edge_mode && active) |=> flag_ff;
  endproperty
  a_level_holds: assert property (p_level_holds)
    else $error("active level did not keep flag set");

  c_edge_ack: cover property (@(posedge clk) disable iff (srst)
    flag_ff && edge_mode && vector_ack ##1 !flag_ff);

endmodule : dtc_ext_irq

/* File: verif/dtc_pin_model.sv */
// pin-side model: external count pins and external interrupt inputs
module dtc_pin_model (
  input  wire logic       clk,
  output logic      [1:0] cnt_pin,   // count pins, idle high
  output logic      [1:0] irq_pin    // interrupt inputs, idle low
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels from time zero so nothing counts before the bench asks
  initial begin
    cnt_pin = 2'h3;
    irq_pin = 2'h0;
  end

  // n falling edges on one pin; gap sets prompt (1) or slow (>1) pulses
  task automatic pulse(input int w, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      cnt_pin[w] = 1'b0;
      repeat (gap) @(negedge clk);
      cnt_pin[w] = 1'b1;
      repeat (gap - 1) @(negedge clk);
    end
  endtask : pulse

  // move one interrupt input, always off the sampling edge
  task automatic set_irq(input int w, input logic v);
    @(negedge clk);
    irq_pin[w] = v;
  endtask : set_irq
endmodule : dtc_pin_model

/* File: verif/dual_timer_counter_ext_irq_tb.sv */
// self-checking bench for the dual timer/counter and external interrupt flags
module dual_timer_counter_ext_irq_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic       clk, srst, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, rdata;
  logic [1:0] cnt_pin, irq_pin, irq_pol, clk_sel, flg_t, flg_e;
  logic [3:0] acks;                  // t0, t1, e0, e1 vector pulses
  int         num_errors, total_checks;

  dtc_pin_model pm_u (.clk(clk), .cnt_pin(cnt_pin), .irq_pin(irq_pin));

  dtc_timer_top dut_u (
    .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_ff(rdata),
    .timer0_count_pin(cnt_pin[0]), .timer1_count_pin(cnt_pin[1]),
    .ext_irq0_input(irq_pin[0]), .ext_irq1_input(irq_pin[1]),
    .ext_irq0_polarity(irq_pol[0]), .ext_irq1_polarity(irq_pol[1]),
    .timer0_clock_select(clk_sel[0]), .timer1_clock_select(clk_sel[1]),
    .timer0_vector_ack(acks[0]), .timer1_vector_ack(acks[1]),
    .ext_irq0_vector_ack(acks[2]), .ext_irq1_vector_ack(acks[3]),
    .timer0_overflow_flag(flg_t[0]), .timer1_overflow_flag(flg_t[1]),
    .ext_irq0_flag(flg_e[0]), .ext_irq1_flag(flg_e[1]));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  // read strobe, data is registered at the taking edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(rdata, exp);
  endtask : rdc

  task automatic ack(input int i);
    @(negedge clk);
    acks[i] = 1'b1;
    @(negedge clk);
    acks[i] = 1'b0;
  endtask : ack

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdc(dtc_pkg::ADDR_CTRL, dtc_pkg::CTRL_RESET);
    rdc(dtc_pkg::ADDR_MODE, dtc_pkg::MODE_RESET);
    rdc(dtc_pkg::ADDR_TL0, dtc_pkg::COUNT_RESET);
    rdc(8'h90, dtc_pkg::RDATA_IDLE);  // unmapped place answers idle
    $display("test reset done");
  endtask : t_reset

  // 16-bit rollover on the fast internal clock, then vector clear
  task automatic t_ovf0;
    int n;
    clk_sel[0] = 1'b1;
    wr(dtc_pkg::ADDR_MODE, 8'h01);
    wr(dtc_pkg::ADDR_TL0, 8'hFF);
    wr(dtc_pkg::ADDR_TH0, 8'hFF);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    n = 0;
    while (flg_t[0] !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(8'(flg_t[0]), 8'h01);
    ack(0);
    chk(8'(flg_t[0]), 8'h00);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    $display("test overflow0 done");
  endtask : t_ovf0

  // prescaled timer 0 and fast timer 1 over one 120-edge run window
  task automatic t_presc;
    clk_sel = 2'h2;
    wr(dtc_pkg::ADDR_MODE, 8'h11);
    wr(dtc_pkg::ADDR_TL0, 8'h00);
    wr(dtc_pkg::ADDR_TL1, 8'h00);
    wr(dtc_pkg::ADDR_CTRL, 8'h50);
    repeat (118) @(negedge clk);      // run window is this plus two edges
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    rdc(dtc_pkg::ADDR_TL0, 8'h0A);
    rdc(dtc_pkg::ADDR_TL1, 8'h78);
    $display("test prescale done");
  endtask : t_presc

  // gated pin counting: blocked, then counting, then stopped by run bit
  task automatic t_gate;
    wr(dtc_pkg::ADDR_MODE, 8'h0D);
    wr(dtc_pkg::ADDR_TL0, 8'h00);
    wr(dtc_pkg::ADDR_TH0, 8'h00);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    pm_u.pulse(0, 3, 1);
    rdc(dtc_pkg::ADDR_TL0, 8'h00);
    pm_u.set_irq(0, 1'b1);
    pm_u.pulse(0, 3, 2);
    rdc(dtc_pkg::ADDR_TL0, 8'h03);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    pm_u.pulse(0, 2, 1);
    rdc(dtc_pkg::ADDR_TL0, 8'h03);
    pm_u.set_irq(0, 1'b0);
    $display("test gate done");
  endtask : t_gate

  // 13-bit rollover and split mode low byte on timer 0
  task automatic t_modes0;
    wr(dtc_pkg::ADDR_MODE, 8'h04);
    wr(dtc_pkg::ADDR_TL0, 8'h1F);
    wr(dtc_pkg::ADDR_TH0, 8'hFF);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    pm_u.pulse(0, 1, 1);
    rdc(dtc_pkg::ADDR_TH0, 8'h00);
    chk(8'(flg_t[0]), 8'h01);
    wr(dtc_pkg::ADDR_MODE, 8'h07);
    wr(dtc_pkg::ADDR_TL0, 8'hFF);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    pm_u.pulse(0, 1, 1);
    rdc(dtc_pkg::ADDR_TL0, 8'h00);
    chk(8'(flg_t[0]), 8'h01);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    $display("test modes0 done");
  endtask : t_modes0

  // timer 1 reload through overflow, then inactive mode freezes it
  task automatic t_tmr1;
    wr(dtc_pkg::ADDR_MODE, 8'h60);
    wr(dtc_pkg::ADDR_TH1, 8'hF0);
    wr(dtc_pkg::ADDR_TL1, 8'hFE);
    wr(dtc_pkg::ADDR_CTRL, 8'h40);
    pm_u.pulse(1, 3, 1);
    rdc(dtc_pkg::ADDR_TL1, 8'hF1);
    chk(8'(flg_t[1]), 8'h01);
    ack(1);
    chk(8'(flg_t[1]), 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h70);
    pm_u.pulse(1, 2, 1);
    rdc(dtc_pkg::ADDR_TL1, 8'hF1);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    $display("test timer1 done");
  endtask : t_tmr1

  // edge mode clears on vector, level mode holds while input active
  task automatic t_ext(input int i);
    wr(dtc_pkg::ADDR_CTRL, 8'h05);
    pm_u.set_irq(i, 1'b1);
    @(negedge clk);
    chk(8'(flg_e[i]), 8'h01);
    ack(2 + i);
    chk(8'(flg_e[i]), 8'h00);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    @(negedge clk);
    ack(2 + i);
    chk(8'(flg_e[i]), 8'h01);
    pm_u.set_irq(i, 1'b0);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    chk(8'(flg_e[i]), 8'h00);
    // active-low polarity: a low input now counts as active
    irq_pol[i] = 1'b0;
    @(negedge clk);
    chk(8'(flg_e[i]), 8'h01);
    irq_pol[i] = 1'b1;
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    chk(8'(flg_e[i]), 8'h00);
    $display("test ext irq %0d done", i);
  endtask : t_ext

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h0;
    irq_pol = 2'h3;
    clk_sel = 2'h0;
    acks = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_ovf0();
    t_gate();
    t_modes0();
    t_tmr1();
    t_presc();
    t_ext(0);
    t_ext(1);
    summarize();
  end
endmodule : dual_timer_counter_ext_irq_tb
